// *** pfmux_pad_function_mux.sv ***
// Summary of operation
// - each pad routes exactly one selected signal
// - mode decoded from lowest four control bits
// - mode zero selects the ball's primary signal
// - reset disables every pad output driver
// - software pull enable independent of function
`timescale 1ns/10ps
`include "pfmux_params.svh"
module pfmux_pad_function_mux (
  input  wire logic                                          clk,
  input  wire logic                                          sys_rst,
  input  wire logic [`PFMUX_NUM_PADS-1:0]                    ctrl_we,
  input  wire logic [`PFMUX_NUM_PADS*`PFMUX_CTRL_W-1:0]      ctrl_wdata,
  input  wire logic [`PFMUX_NUM_PADS*`PFMUX_NUM_SRC-1:0]     func_out,
  input  wire logic [`PFMUX_NUM_PADS*`PFMUX_NUM_SRC-1:0]     func_oe,
  input  wire logic [`PFMUX_NUM_PADS-1:0]                    pad_in,
  output logic      [`PFMUX_NUM_PADS*`PFMUX_CTRL_W-1:0]      ctrl_rdata,
  output logic      [`PFMUX_NUM_PADS-1:0]                    pad_out,
  output logic      [`PFMUX_NUM_PADS-1:0]                    pad_oe,
  output logic      [`PFMUX_NUM_PADS-1:0]                    pad_pull_en,
  output logic      [`PFMUX_NUM_PADS*`PFMUX_NUM_SRC-1:0]     func_in
);
  // ---------------------------------------------------------------
  // per-pad control and routing
  // ---------------------------------------------------------------
  // unbonded pads rely on software to clear their drive
  genvar g;
  for (g = 0; g < `PFMUX_NUM_PADS; g++) begin : g_pad
    pfmux_pkg::pfmux_ctrl_t pad_function_select_register;
    pfmux_pkg::pfmux_sel_t  sel;
    logic [2:0]             in_sync;
    logic [`PFMUX_NUM_SRC-1:0] outs;
    logic [`PFMUX_NUM_SRC-1:0] oes;
    logic [`PFMUX_NUM_SRC-1:0] fin;
    assign outs = func_out[g*`PFMUX_NUM_SRC +: `PFMUX_NUM_SRC];
    assign oes  = func_oe[g*`PFMUX_NUM_SRC +: `PFMUX_NUM_SRC];
    assign sel  = pad_function_select_register[`PFMUX_SEL_MSB:`PFMUX_SEL_LSB];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pad_function_select_register <= `PFMUX_CTRL_RST;
      end else if (ctrl_we[g]) begin
        pad_function_select_register <= ctrl_wdata[g*`PFMUX_CTRL_W +: `PFMUX_CTRL_W];
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pad_oe[g]  <= 1'b0;
        pad_out[g] <= 1'b0;
      end else begin
        pad_oe[g]  <= oes[sel];
        pad_out[g] <= outs[sel];
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pad_pull_en[g] <= 1'(`PFMUX_CTRL_RST >> `PFMUX_PULL_BIT);
      end else begin
        pad_pull_en[g] <= pad_function_select_register[`PFMUX_PULL_BIT];
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ctrl_rdata[g*`PFMUX_CTRL_W +: `PFMUX_CTRL_W] <= `PFMUX_CTRL_RST;
      end else begin
        ctrl_rdata[g*`PFMUX_CTRL_W +: `PFMUX_CTRL_W] <= pad_function_select_register;
      end
    end

    // pin input: three stages, change accepted when last two agree
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        in_sync <= 3'h0;
      end else begin
        in_sync <= {in_sync[1:0], pad_in[g]};
      end
    end

    // only the selected function sees the ball; others read zero
    // local vector keeps each pad's process on its own variable
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        fin <= '0;
      end else begin
        for (int s = 0; s < `PFMUX_NUM_SRC; s++) begin
          if (s[`PFMUX_SEL_W-1:0] == sel) begin
            if (in_sync[2] == in_sync[1]) begin
              fin[s] <= in_sync[2];
            end
          end else begin
            fin[s] <= 1'b0;
          end
        end
      end
    end

    assign func_in[g*`PFMUX_NUM_SRC +: `PFMUX_NUM_SRC] = fin;
  end
endmodule : pfmux_pad_function_mux

// *** pfmux_params.svh ***
`ifndef PFMUX_PARAMS_SVH
`define PFMUX_PARAMS_SVH
// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define PFMUX_NUM_PADS     4
`define PFMUX_SEL_W        4
`define PFMUX_CTRL_W       8
`define PFMUX_NUM_SRC      16
`define PFMUX_SEL_LSB      0
`define PFMUX_SEL_MSB      3
`define PFMUX_PULL_BIT     4
`define PFMUX_MODE_PRIMARY 4'h0
`define PFMUX_CTRL_RST     8'h10
`endif

// *** pfmux_pkg.sv ***
`include "pfmux_params.svh"
package pfmux_pkg;
  typedef logic [`PFMUX_SEL_W-1:0]  pfmux_sel_t;
  typedef logic [`PFMUX_CTRL_W-1:0] pfmux_ctrl_t;
endpackage : pfmux_pkg

// *** pfmux_checker.sv ***
`timescale 1ns/10ps
// ----
// reset checks on all four pads, then pad 0 checks
// ----
module pfmux_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  ctrl_we,
  input wire logic [31:0] ctrl_wdata,
  input wire logic [63:0] func_out,
  input wire logic [63:0] func_oe,
  input wire logic [31:0] ctrl_rdata,
  input wire logic [3:0]  pad_out,
  input wire logic [3:0]  pad_oe,
  input wire logic [3:0]  pad_pull_en
);
  a_reset_oe_off: assert property (@(posedge clk) sys_rst |=> pad_oe == 4'h0)
    else $error("driver on after reset");
  a_reset_primary: assert property (@(posedge clk) sys_rst |=> ctrl_rdata == 32'h10101010)
    else $error("control not at reset value");
  a_mode_store: assert property (@(posedge clk) disable iff (sys_rst) ctrl_we[0] ##1 !ctrl_we[0]
    |-> ##1 ctrl_rdata[3:0] == $past(ctrl_wdata[3:0], 2)) else $error("mode not stored");
  a_pull_follow: assert property (@(posedge clk) disable iff (sys_rst) ctrl_we[0] ##1 !ctrl_we[0]
    |-> ##1 pad_pull_en[0] == $past(ctrl_wdata[4], 2)) else $error("pull enable wrong");
  a_route_data: assert property (@(posedge clk) disable iff (sys_rst) ctrl_we[0] ##1 !ctrl_we[0]
    |-> ##1 pad_out[0] == 1'($past(func_out[15:0]) >> ctrl_rdata[3:0])) else $error("wrong source");
  a_primary_oe: assert property (@(posedge clk) disable iff (sys_rst) ctrl_we[0] &&
    ctrl_wdata[3:0] == 4'h0 ##1 !ctrl_we[0] |-> ##1 pad_oe[0] == $past(func_oe[0]))
    else $error("primary enable wrong");
endmodule : pfmux_checker
bind pfmux_pad_function_mux pfmux_checker chk (.*);

// *** pfmux_pad_function_mux_test.sv ***
`timescale 1ns/10ps
module pfmux_pad_function_mux_test;
  logic        clk = 0, sys_rst = 1;
  logic [3:0]  ctrl_we = 4'h0, pad_in = 4'h0, pad_out, pad_oe, pad_pull_en;
  logic [31:0] ctrl_wdata = 32'h0, ctrl_rdata;
  logic [63:0] func_out = 64'ha5, func_oe = 64'hff, func_in;
  int          n_fail = 0, checked = 0;
  // wdata, then {pull, out, oe} expected
  logic [11:0] rows [5] = '{12'h003, 12'he53, 12'h1a4, 12'h0f0, 12'h115};
  always #5 clk = ~clk;
  pfmux_pad_function_mux dut (.*);
  task chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // outputs settle one edge after the write edge
  task wr(logic [7:0] d);
    @(posedge clk) #1;
    ctrl_we[0] = 1'b1;
    ctrl_wdata[7:0] = d;
    @(posedge clk) #1;
    ctrl_we[0] = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task test_done;
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(ctrl_rdata, 32'h10101010);
    chk(pad_oe, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i][11:4]);
      chk({pad_pull_en[0], pad_out[0], pad_oe[0]}, rows[i][2:0]);
    end
    wr(8'h01);
    sys_rst = 1'b1;
    @(posedge clk) #1;
    sys_rst = 1'b0;
    chk(pad_oe, 32'h0);
    chk(ctrl_rdata[7:0], 32'h10);
    chk(pad_pull_en, 32'hf);
    pad_in[0] = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(func_in[15:0], 32'h1);
    wr(8'h02);
    chk(func_in[15:0], 32'h4);
    chk(func_in[63:16], 32'h0);
    test_done();
  end
endmodule : pfmux_pad_function_mux_test
